//--- bta_pkg.sv
// shared constants and types for the battery tracking gain controller
package bta_pkg;

   // register offsets on the serial control port
   localparam logic [7:0] OFS_INFLECTION = 8'h0b;
   localparam logic [7:0] OFS_SLOPE = 8'h0c;
   localparam logic [7:0] OFS_FIXED_GAIN = 8'h0d;
   localparam logic [7:0] OFS_ATTACK = 8'h0e;
   localparam logic [7:0] OFS_RELEASE = 8'h0f;
   localparam logic [7:0] OFS_STATUS = 8'h11;

   // values after reset
   localparam logic [7:0] RST_INFLECTION = 8'h00;
   localparam logic [7:0] RST_SLOPE = 8'h00;
   localparam logic [4:0] RST_FIXED_GAIN = 5'h07;
   localparam logic [2:0] RST_ATTACK = 3'h0;
   localparam logic [3:0] RST_RELEASE = 4'h0;

   // field widths and positions
   localparam int ATK_W = 3;
   localparam int REL_W = 4;
   localparam int GAIN_W = 5;
   localparam int ATK_LSB = 0;
   localparam int REL_LSB = 0;

   // seven bit device address on the control port
   localparam logic [6:0] DEV_ADDR = 7'h40;

   // limiter arithmetic, kept in units of 1/10000 of one level code
   localparam logic [16:0] SLOPE_BASE_Q = 17'h02ee0;
   localparam logic [16:0] SLOPE_STEP_Q = 17'h00175;
   localparam logic [13:0] LVL_SCALE = 14'h2710;

   // clock and per-step gain intervals
   localparam int CLK_HZ = 10_000_000;
   localparam int ATK_BASE_US = 20;
   localparam int ATK_STEP_US = 350;
   localparam int REL_BASE_MS = 50;
   localparam int REL_STEP_MS = 105;
   localparam int ATK_BASE_CYC = ATK_BASE_US * (CLK_HZ / 1_000_000);
   localparam int ATK_STEP_CYC = ATK_STEP_US * (CLK_HZ / 1_000_000);
   localparam int REL_BASE_CYC = REL_BASE_MS * (CLK_HZ / 1000);
   localparam int REL_STEP_CYC = REL_STEP_MS * (CLK_HZ / 1000);
   localparam int TMR_W = 24;

   // control port protocol states, gray along the write path and the read byte loop
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_AACK = 4'h3,
      ST_PTR = 4'h2,
      ST_PACK = 4'h6,
      ST_WDAT = 4'h7,
      ST_WACK = 4'h5,
      ST_RDAT = 4'h4,
      ST_RACK = 4'hc
   } bta_i2c_st_t;

   // gain adjustment direction
   typedef enum logic [1:0] {
      DIR_HOLD = 2'h0,
      DIR_ATTACK = 2'h1,
      DIR_RELEASE = 2'h3
   } bta_dir_t;

endpackage : bta_pkg

//--- bta_reg_if.sv
// register access path between the control port and the register file
`timescale 1ns/1ps
`default_nettype none
interface bta_reg_if;
   logic wr;          // one cycle write strobe
   logic [7:0] addr;  // register pointer
   logic [7:0] wdata; // data to write
   logic [7:0] rdata; // read data for addr

   modport port (output wr, output addr, output wdata, input rdata);
   modport regs (input wr, input addr, input wdata, output rdata);
endinterface : bta_reg_if
`default_nettype wire

//--- bta_i2c_slave.sv
// two wire control port slave with auto incrementing register pointer
`timescale 1ns/1ps
`default_nettype none
module bta_i2c_slave (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_oe_n,
   bta_reg_if.port bus
);
   bta_pkg::bta_i2c_st_t st_r; // protocol state
   logic scl_q;       // previous clock sample
   logic sda_q;       // previous data sample
   logic [7:0] sh_r;  // receive shift register
   logic [7:0] tx_r;  // transmit shift register
   logic [2:0] cnt_r; // bits seen in this byte
   logic got8_r;      // a whole byte has been received
   logic rw_r;        // transfer direction, high for read
   logic [7:0] ptr_r; // register pointer
   logic wr_r;        // write strobe
   logic [7:0] wdat_r; // write data
   logic oe_n_r;      // low pulls the data line down

   // edge and condition decode
   wire logic scl_rise = i_scl & ~scl_q;
   wire logic scl_fall = ~i_scl & scl_q;
   wire logic start_c = i_scl & scl_q & sda_q & ~i_sda;
   wire logic stop_c = i_scl & scl_q & ~sda_q & i_sda;
   wire logic addr_hit = (sh_r[7:1] == bta_pkg::DEV_ADDR);
   wire logic shifting = (st_r == bta_pkg::ST_ADDR) |
      (st_r == bta_pkg::ST_PTR) | (st_r == bta_pkg::ST_WDAT) |
      (st_r == bta_pkg::ST_RDAT);

   assign bus.wr = wr_r;
   assign bus.addr = ptr_r;
   assign bus.wdata = wdat_r;
   assign o_sda_oe_n = oe_n_r;

   // line sampling for edge detection
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end

   // bit capture on clock rise; data is sampled while the clock is high
   always_ff @(posedge i_clk) begin
      if (i_rst || start_c || (scl_fall && got8_r)) begin
         cnt_r <= 3'h0;
         got8_r <= 1'b0;
      end else if (scl_rise && shifting) begin
         sh_r <= {sh_r[6:0], i_sda};
         cnt_r <= cnt_r + 3'h1;
         got8_r <= (cnt_r == 3'h7);
      end
   end

   // protocol sequencing; the line only changes while the clock is low
   always_ff @(posedge i_clk) begin
      wr_r <= 1'b0;
      if (i_rst) begin
         st_r <= bta_pkg::ST_IDLE;
         oe_n_r <= 1'b1;
         rw_r <= 1'b0;
         ptr_r <= 8'h00;
         tx_r <= 8'hff;
         wdat_r <= 8'h00;
      end else if (start_c) begin
         // a repeated start keeps the pointer for a read back
         st_r <= bta_pkg::ST_ADDR;
         oe_n_r <= 1'b1;
      end else if (stop_c) begin
         st_r <= bta_pkg::ST_IDLE;
         oe_n_r <= 1'b1;
      end else if (scl_rise && st_r == bta_pkg::ST_RACK && i_sda) begin
         // master refused further data: let go of the line
         st_r <= bta_pkg::ST_IDLE;
      end else if (scl_fall) begin
         unique case (st_r)
            bta_pkg::ST_IDLE: begin
               oe_n_r <= 1'b1;
            end
            bta_pkg::ST_ADDR: begin
               if (got8_r) begin
                  // other addresses are ignored without acknowledge
                  st_r <= addr_hit ? bta_pkg::ST_AACK : bta_pkg::ST_IDLE;
                  oe_n_r <= ~addr_hit;
                  rw_r <= sh_r[0];
               end
            end
            bta_pkg::ST_AACK: begin
               if (rw_r) begin
                  st_r <= bta_pkg::ST_RDAT;
                  tx_r <= bus.rdata;
                  oe_n_r <= bus.rdata[7];
                  ptr_r <= ptr_r + 8'h01;
               end else begin
                  st_r <= bta_pkg::ST_PTR;
                  oe_n_r <= 1'b1;
               end
            end
            bta_pkg::ST_PTR: begin
               if (got8_r) begin
                  ptr_r <= sh_r;
                  st_r <= bta_pkg::ST_PACK;
                  oe_n_r <= 1'b0;
               end
            end
            bta_pkg::ST_PACK: begin
               st_r <= bta_pkg::ST_WDAT;
               oe_n_r <= 1'b1;
            end
            bta_pkg::ST_WDAT: begin
               if (got8_r) begin
                  wr_r <= 1'b1;
                  wdat_r <= sh_r;
                  st_r <= bta_pkg::ST_WACK;
                  oe_n_r <= 1'b0;
               end
            end
            bta_pkg::ST_WACK: begin
               // pointer moves on so a burst fills following registers
               ptr_r <= ptr_r + 8'h01;
               st_r <= bta_pkg::ST_WDAT;
               oe_n_r <= 1'b1;
            end
            bta_pkg::ST_RDAT: begin
               if (got8_r) begin
                  st_r <= bta_pkg::ST_RACK;
                  oe_n_r <= 1'b1;
               end else begin
                  tx_r <= {tx_r[6:0], 1'b1};
                  oe_n_r <= tx_r[6];
               end
            end
            bta_pkg::ST_RACK: begin
               st_r <= bta_pkg::ST_RDAT;
               tx_r <= bus.rdata;
               oe_n_r <= bus.rdata[7];
               ptr_r <= ptr_r + 8'h01;
            end
            default: begin
               st_r <= bta_pkg::ST_IDLE;
               oe_n_r <= 1'b1;
            end
         endcase
      end
   end
endmodule : bta_i2c_slave
`default_nettype wire

//--- bta_agc.sv
// battery tracking automatic gain controller with its register file
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - watch battery and audio level continuously
// - inflection voltage register, 17.33 mV codes
// - above inflection, limit follows boost ceiling
// - below inflection, limit follows programmed slope
// - slope register, 1.2 V/V plus 37.3 mV/V
// - only excess output level, or a fixed gain code written below the present gain, reduces gain
// - over limit, step gain down
// - under limit, restore gain toward fixed gain
// - attack interval 20 plus 350n us
// - release interval 50 plus 105n ms
// - fixed gain code, -7 dB plus code
module bta_agc #(
   parameter int P_ATK_BASE_CYC = bta_pkg::ATK_BASE_CYC,
   parameter int P_ATK_STEP_CYC = bta_pkg::ATK_STEP_CYC,
   parameter int P_REL_BASE_CYC = bta_pkg::REL_BASE_CYC,
   parameter int P_REL_STEP_CYC = bta_pkg::REL_STEP_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   input wire logic [7:0] i_vbat,
   input wire logic [11:0] i_boost_level,
   input wire logic [11:0] i_out_level,
   output logic [4:0] o_gain,
   output logic o_limiting
);
   bta_reg_if rif ();

   logic [7:0] infl_r;  // inflection voltage code
   logic [7:0] slope_r; // limit versus battery slope code
   logic [4:0] fixed_r; // fixed gain code
   logic [2:0] atk_r;   // attack interval code
   logic [3:0] rel_r;   // release interval code
   logic [4:0] gain_r;  // present gain code
   logic [4:0] gain_nxt;
   bta_pkg::bta_dir_t dir_r;   // direction chosen on the previous cycle
   bta_pkg::bta_dir_t dir_nxt;
   logic [23:0] tmr_r;  // cycles spent waiting for the next step
   logic [23:0] tmr_nxt;
   logic sda_r;         // open drain data only ever drives low

   // control port; the bus only drives the pointer, data and strobe
   bta_i2c_slave u_port (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda_oe_n(o_sda_oe_n),
      .bus(rif.port)
   );

   // register decode
   wire logic wr_infl = rif.wr & (rif.addr == bta_pkg::OFS_INFLECTION);
   wire logic wr_slope = rif.wr & (rif.addr == bta_pkg::OFS_SLOPE);
   wire logic wr_fixed = rif.wr & (rif.addr == bta_pkg::OFS_FIXED_GAIN);
   wire logic wr_atk = rif.wr & (rif.addr == bta_pkg::OFS_ATTACK);
   wire logic wr_rel = rif.wr & (rif.addr == bta_pkg::OFS_RELEASE);

   // status shows the controller's own activity and present gain
   wire logic [7:0] status_v = {1'b0, dir_r == bta_pkg::DIR_RELEASE,
      dir_r == bta_pkg::DIR_ATTACK, gain_r};

   // read mux; unmapped pointers read as zero
   assign rif.rdata =
      (rif.addr == bta_pkg::OFS_INFLECTION) ? infl_r :
      (rif.addr == bta_pkg::OFS_SLOPE) ? slope_r :
      (rif.addr == bta_pkg::OFS_FIXED_GAIN) ? {3'h0, fixed_r} :
      (rif.addr == bta_pkg::OFS_ATTACK) ? {5'h00, atk_r} :
      (rif.addr == bta_pkg::OFS_RELEASE) ? {4'h0, rel_r} :
      (rif.addr == bta_pkg::OFS_STATUS) ? status_v : 8'h00;

   // register file writes; unused bits of a field are dropped
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         infl_r <= bta_pkg::RST_INFLECTION;
         slope_r <= bta_pkg::RST_SLOPE;
         fixed_r <= bta_pkg::RST_FIXED_GAIN;
         atk_r <= bta_pkg::RST_ATTACK;
         rel_r <= bta_pkg::RST_RELEASE;
      end else begin
         if (wr_infl) infl_r <= rif.wdata;
         if (wr_slope) slope_r <= rif.wdata;
         if (wr_fixed) fixed_r <= rif.wdata[bta_pkg::GAIN_W-1:0];
         if (wr_atk) atk_r <= rif.wdata[bta_pkg::ATK_LSB +: 3];
         if (wr_rel) rel_r <= rif.wdata[bta_pkg::REL_LSB +: 4];
      end
   end

   // peak output limit, all terms scaled by 10000 so the 37.3 mV/V
   // slope steps stay exact without a divider
   wire logic vbat_above = (i_vbat >= infl_r);
   wire logic [7:0] vbat_gap = infl_r - i_vbat;
   wire logic [31:0] slope_w = 32'(bta_pkg::SLOPE_BASE_Q) +
      32'(bta_pkg::SLOPE_STEP_Q) * {24'h000000, slope_r};
   wire logic [16:0] slope_q = slope_w[16:0];
   wire logic [27:0] drop_s = 28'({17'h0, vbat_gap} * {8'h00, slope_q});
   wire logic [27:0] ceil_s = 28'({16'h0000, i_boost_level} *
      {14'h0, bta_pkg::LVL_SCALE});
   wire logic [27:0] lvl_s = 28'({16'h0000, i_out_level} *
      {14'h0, bta_pkg::LVL_SCALE});
   wire logic [27:0] slope_lim = (ceil_s > drop_s) ? ceil_s - drop_s :
      28'h0000000;
   wire logic [27:0] lim_s = vbat_above ? ceil_s : slope_lim;
   // low battery alone never trips this; only output above the limit
   wire logic over_lim = (lvl_s > lim_s);

   // per-step intervals in clock cycles
   wire logic [31:0] atk_iv = 32'(P_ATK_BASE_CYC) +
      32'(P_ATK_STEP_CYC) * {29'h0, atk_r};
   wire logic [31:0] rel_iv = 32'(P_REL_BASE_CYC) +
      32'(P_REL_STEP_CYC) * {28'h0000000, rel_r};

   // direction decision
   wire logic want_atk = over_lim & (gain_r != 5'h00);
   wire logic want_rel = ~over_lim & (gain_r < fixed_r);
   wire logic [23:0] step_iv = (dir_nxt == bta_pkg::DIR_ATTACK) ?
      atk_iv[23:0] : rel_iv[23:0];
   wire logic step_due = (tmr_r + 24'h000001 >= step_iv);

   // next gain, direction and timer
   always_comb begin
      dir_nxt = want_atk ? bta_pkg::DIR_ATTACK :
         want_rel ? bta_pkg::DIR_RELEASE : bta_pkg::DIR_HOLD;
      gain_nxt = gain_r;
      tmr_nxt = 24'h000000;
      if (~over_lim && gain_r > fixed_r) begin
         // fixed gain was lowered by software: follow it at once
         gain_nxt = fixed_r;
      end else if (dir_nxt != dir_r) begin
         tmr_nxt = 24'h000000;
      end else if (dir_nxt == bta_pkg::DIR_HOLD) begin
         tmr_nxt = 24'h000000;
      end else if (step_due) begin
         // one dB per elapsed interval
         if (dir_nxt == bta_pkg::DIR_ATTACK) begin
            gain_nxt = gain_r - 5'h01;
         end else begin
            gain_nxt = gain_r + 5'h01;
         end
      end else begin
         tmr_nxt = tmr_r + 24'h000001;
      end
   end

   // gain regulation state
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         gain_r <= bta_pkg::RST_FIXED_GAIN;
         dir_r <= bta_pkg::DIR_HOLD;
         tmr_r <= 24'h000000;
      end else begin
         gain_r <= gain_nxt;
         dir_r <= dir_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   // outputs straight from flops
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_gain <= bta_pkg::RST_FIXED_GAIN;
         o_limiting <= 1'b0;
         sda_r <= 1'b0;
      end else begin
         o_gain <= gain_nxt;
         o_limiting <= (dir_nxt == bta_pkg::DIR_ATTACK);
         sda_r <= 1'b0;
      end
   end

   assign o_sda = sda_r;
endmodule : bta_agc
`default_nettype wire

//--- bta_monitor.sv
// port assertions for the battery tracking gain controller
`timescale 1ns/1ps
`default_nettype none
module bta_monitor #(
   parameter int P_ATK_BASE_CYC = 4,
   parameter int P_ATK_STEP_CYC = 3,
   parameter int P_REL_BASE_CYC = 50,
   parameter int P_REL_STEP_CYC = 20
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe_n,
   input wire logic [7:0] i_vbat,
   input wire logic [11:0] i_boost_level,
   input wire logic [11:0] i_out_level,
   input wire logic [4:0] o_gain,
   input wire logic o_limiting
);
   // longest attack wait, with slack for direction entry
   localparam int ATK_MAX = P_ATK_BASE_CYC + 7 * P_ATK_STEP_CYC + 2;
   logic [4:0] gain_q; // gain seen one edge ago
   logic [23:0] hold_r; // edges the gain has stood still
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // count how long the gain holds, so step spacing can be judged
   always_ff @(posedge i_clk) begin
      gain_q <= o_gain;
      hold_r <= (i_rst || o_gain != gain_q) ? 24'h0 : hold_r + 24'h1;
   end
   // a gain step, or the attack having ended
   sequence s_step_or_quit;
      $changed(o_gain) || !o_limiting;
   endsequence
   // attack starts, then a step must follow in time
   property p_attack_due;
      $rose(o_limiting) |-> ##[1:ATK_MAX] s_step_or_quit;
   endproperty
   reset_gain_a: assert property ($fell(i_rst) |-> o_gain == 5'h07 && !o_limiting) else $error("gain not at 0 dB after reset");
   step_up_one_a: assert property (o_gain > $past(o_gain) |-> o_gain == $past(o_gain) + 5'h01) else $error("release step not one code");
   step_down_one_a: assert property ($past(o_limiting) && o_gain < $past(o_gain) |-> o_gain == $past(o_gain) - 5'h01) else $error("attack step not one code");
   no_rise_attack_a: assert property (o_limiting |-> o_gain <= $past(o_gain)) else $error("gain rose while limiting");
   // only a full-scale battery code is surely above any inflection, so only
   // then is the boost ceiling known to be the limit from the ports alone
   under_boost_quiet_a: assert property ($past(i_vbat) == 8'hff && $past(i_out_level) <= $past(i_boost_level) |-> !o_limiting) else $error("limiting without excess level");
   over_boost_flag_a: assert property ($past(i_out_level > i_boost_level) && $past(o_gain) > 5'h01 |-> o_limiting) else $error("excess level not limited");
   attack_gap_a: assert property ($past(o_limiting) && o_gain < $past(o_gain) |-> $past(hold_r) >= 24'(P_ATK_BASE_CYC - 2)) else $error("attack step too early");
   release_gap_a: assert property (o_gain > $past(o_gain) |-> $past(hold_r) >= 24'(P_REL_BASE_CYC - 2)) else $error("release step too early");
   attack_due_a: assert property (p_attack_due) else $error("attack step overdue");
   sda_low_only_a: assert property (o_sda == 1'b0) else $error("data line driven high");
   sda_change_a: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl)) else $error("data drive moved while clock high");
endmodule : bta_monitor
bind bta_agc bta_monitor #(.P_ATK_BASE_CYC(P_ATK_BASE_CYC), .P_ATK_STEP_CYC(P_ATK_STEP_CYC), .P_REL_BASE_CYC(P_REL_BASE_CYC), .P_REL_STEP_CYC(P_REL_STEP_CYC)) u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_vbat(i_vbat), .i_boost_level(i_boost_level), .i_out_level(i_out_level), .o_gain(o_gain), .o_limiting(o_limiting));
`default_nettype wire

//--- bta_stage_model.sv
// output stage model: level grows with the applied gain
`timescale 1ns/1ps
`default_nettype none
module bta_stage_model (
   input wire logic [11:0] i_audio,
   input wire logic [4:0] i_gain,
   output logic [11:0] o_out_level
);
   // 16 level codes per gain step, so one step can clear a small excess
   assign o_out_level = i_audio + {3'h0, i_gain, 4'h0};
endmodule : bta_stage_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the battery tracking gain controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int AB = 4; // shortened attack and release timing
   localparam int AS = 3;
   localparam int RB = 50;
   localparam int RS = 20;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic scl = 1'b1; // master clock line
   logic sdam = 1'b1; // master data drive, 1 means released
   logic [7:0] vbat = 8'h90;
   logic [11:0] boost = 12'h200;
   logic [11:0] audio = 12'h000;
   wire [11:0] out_level;
   logic o_sda, o_sda_oe_n, o_limiting, a;
   logic [4:0] o_gain;
   logic [7:0] d;
   wire sda = sdam & (o_sda_oe_n | o_sda); // pulled-up open drain wire
   int failures = 0;
   int total_checks = 0;
   int n;
   always #50 i_clk = ~i_clk;
   bta_stage_model u_stage (.i_audio(audio), .i_gain(o_gain), .o_out_level(out_level));
   bta_agc #(.P_ATK_BASE_CYC(AB), .P_ATK_STEP_CYC(AS), .P_REL_BASE_CYC(RB), .P_REL_STEP_CYC(RS)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_vbat(vbat), .i_boost_level(boost), .i_out_level(out_level), .o_gain(o_gain), .o_limiting(o_limiting));
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask : tick
   // one bit slot; the line is read late in the high phase
   task automatic bitx(input logic b, output logic r);
      @(posedge i_clk);
      sdam <= b;
      tick(3);
      scl <= 1'b1;
      tick(3);
      @(negedge i_clk);
      r = sda;
      @(posedge i_clk);
      scl <= 1'b0;
      tick(2);
   endtask : bitx
   task automatic start();
      @(posedge i_clk);
      sdam <= 1'b1;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sdam <= 1'b0;
      tick(3);
      scl <= 1'b0;
      tick(2);
   endtask : start
   task automatic stop();
      @(posedge i_clk);
      sdam <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sdam <= 1'b1;
      tick(3);
   endtask : stop
   task automatic tx(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(v[i], r);
      bitx(1'b1, ack);
   endtask : tx
   // single byte then a nack, which ends the read
   task automatic rx(output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
      bitx(1'b1, r);
   endtask : rx
   task automatic wr(input logic [7:0] ad, input logic [7:0] v);
      logic k;
      start();
      tx(8'h80, k);
      chk("address ack", 12'h0, {11'h0, k});
      tx(ad, k);
      tx(v, k);
      chk("data ack", 12'h0, {11'h0, k});
      stop();
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [7:0] v);
      logic k;
      start();
      tx(8'h80, k);
      tx(ad, k);
      start();
      tx(8'h81, k);
      chk("read ack", 12'h0, {11'h0, k});
      rx(v);
      stop();
   endtask : rd
   // edges until the gain moves, bounded; call at a falling edge
   task automatic wait_step(input int lim, output int c);
      logic [4:0] g;
      g = o_gain;
      c = 0;
      while (o_gain === g && c < lim) begin
         @(negedge i_clk);
         c++;
      end
   endtask : wait_step
   task automatic end_sim();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // watchdog well beyond the expected run length
   initial begin
      tick(90000);
      failures++;
      end_sim();
   end
   initial begin
      tick(5);
      i_rst <= 1'b0;
      tick(2);
      @(negedge i_clk);
      chk("reset gain", 12'h007, {7'h0, o_gain});
      for (int i = 11; i <= 15; i++) begin
         rd(i[7:0], d);
         chk("reset reg", (i == 13) ? 12'h007 : 12'h000, {4'h0, d});
      end
      wr(8'h0b, 8'h80);
      wr(8'h0c, 8'h64);
      wr(8'h0e, 8'hff);
      wr(8'h0f, 8'hff);
      rd(8'h0b, d);
      chk("inflection", 12'h080, {4'h0, d});
      rd(8'h0c, d);
      chk("slope", 12'h064, {4'h0, d});
      rd(8'h0e, d);
      chk("attack field", 12'h007, {4'h0, d});
      rd(8'h0f, d);
      chk("release field", 12'h00f, {4'h0, d});
      rd(8'h20, d);
      chk("unmapped", 12'h000, {4'h0, d});
      start();
      tx(8'h84, a);
      chk("foreign ack", 12'h001, {11'h0, a});
      stop();
      // low battery: limit 1024 - 100 * 4.93 = 531
      vbat <= 8'h1c;
      boost <= 12'h400;
      audio <= 12'd419;
      tick(20);
      @(negedge i_clk);
      chk("limit at edge", 12'h0, {11'h0, o_limiting});
      chk("low battery gain", 12'h007, {7'h0, o_gain});
      @(posedge i_clk);
      audio <= 12'd420;
      @(posedge i_clk);
      @(negedge i_clk);
      chk("slope limit", 12'h1, {11'h0, o_limiting});
      @(posedge i_clk);
      audio <= 12'd300;
      tick(40);
      @(negedge i_clk);
      chk("aborted attack", 12'h007, {7'h0, o_gain});
      // high battery: the boost ceiling is the limit
      @(posedge i_clk);
      vbat <= 8'hff;
      boost <= 12'h200;
      audio <= 12'd400;
      tick(3);
      @(negedge i_clk);
      chk("boost edge", 12'h0, {11'h0, o_limiting});
      @(posedge i_clk);
      audio <= 12'd401;
      @(posedge i_clk);
      @(negedge i_clk);
      chk("boost limit", 12'h1, {11'h0, o_limiting});
      @(posedge i_clk);
      audio <= 12'd300;
      // every release code, attack codes wrapping through all eight
      for (int i = 0; i < 16; i++) begin
         wr(8'h0e, {5'h0, i[2:0]});
         wr(8'h0f, {4'h0, i[3:0]});
         audio <= 12'd417;
         @(negedge i_clk);
         wait_step(200, n);
         wait_step(200, n);
         chk("attack interval", 12'(AB + AS * i[2:0]), 12'(n));
         @(posedge i_clk);
         audio <= 12'd399;
         @(negedge i_clk);
         chk("settled gain", 12'h005, {7'h0, o_gain});
         wait_step(1000, n);
         wait_step(1000, n);
         chk("release interval", 12'(RB + RS * i), 12'(n));
         wait_step(RB + RS * i + 20, n);
         chk("release cap", 12'h007, {7'h0, o_gain});
      end
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
